// ===== verilog/imts_pkg.sv
// shared constants and types of the i2c master transmit sequencer
package imts_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL_SET_PORT = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DAT = 8'h08;
  localparam logic [7:0] OFF_ADR = 8'h0C;
  localparam logic [7:0] OFF_SCL_HIGH_COUNT = 8'h10;
  localparam logic [7:0] OFF_SCL_LOW_COUNT = 8'h14;
  localparam logic [7:0] OFF_CONTROL_CLEAR_PORT = 8'h18;
  // control bit positions
  localparam int CON_EN = 6;
  localparam int CON_STA = 5;
  localparam int CON_STO = 4;
  localparam int CON_SI = 3;
  localparam int CON_AA = 2;
  localparam logic [7:0] CON_VALID = 8'h7C;
  // reset values
  localparam logic [7:0] CON_RST = 8'h00;
  localparam logic [7:0] ADR_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'h00;
  localparam logic [15:0] SCL_CNT_RST = 16'h0004;
  // status codes
  localparam logic [7:0] SC_START = 8'h08;
  localparam logic [7:0] SC_RSTART = 8'h10;
  localparam logic [7:0] SC_AW_ACK = 8'h18;
  localparam logic [7:0] SC_AW_NACK = 8'h20;
  localparam logic [7:0] SC_D_ACK = 8'h28;
  localparam logic [7:0] SC_D_NACK = 8'h30;
  localparam logic [7:0] SC_ARB = 8'h38;
  localparam logic [7:0] SC_AR_ACK = 8'h40;
  localparam logic [7:0] SC_AR_NACK = 8'h48;
  localparam logic [7:0] SC_RX_ACK = 8'h50;
  localparam logic [7:0] SC_RX_NACK = 8'h58;
  localparam logic [7:0] SC_SL_W = 8'h68;
  localparam logic [7:0] SC_SL_GC = 8'h78;
  localparam logic [7:0] SC_SL_R = 8'hB0;
  localparam logic [7:0] SC_NONE = 8'hF8;
  // bits per byte before the acknowledge slot
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // sequencer states, gray along idle-start-low-high-hold
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_LOW = 3'b011,
    S_HIGH = 3'b010,
    S_HOLD = 3'b110,
    S_STOP = 3'b111,
    S_RSTA = 3'b101
  } imts_state_t;
endpackage

// ===== verilog/imts_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module imts_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // pin in, filtered level out
  input wire logic din,
  output logic dout
);
  logic ff1_r;
  logic ff2_r;
  logic ff3_r;
  // a change counts only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      ff1_r <= din;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      if (ff2_r == ff3_r) begin
        dout <= ff3_r;
      end
    end
  end
endmodule // imts_sync
`default_nettype wire

// ===== verilog/imts_ctrl.sv
// i2c controller sequencer with apb register file, master transmit focus
// How it works
// - four modes: master transmit, master receive, slave receive, slave transmit. Here the slave modes end at the address ack, then go idle.
// - direction bit after address: high for read, low for write.
// - acknowledge is low on data line in ack slot, high is not-ack.
// - while interrupt flag is set the serial transfer stays suspended.
// - with ack enable clear, own or general call address is never acked.
// - start request waits for a free bus before sending start.
// - after start sent, flag sets with status 0x08.
// - at 0x08 software loads address+write, clears flag; byte shifts out.
// - after address byte status is 0x18, 0x20 or 0x38.
// - with ack enable, lost arbitration and own or general call address matched, report 0x68, 0x78 or 0xB0.
// - at 0x10 address+read switches to master receive, +write continues.
// - 0x18 means address acked; data byte then sent, ack sampled.
// - 0x20 means address not acked; same four responses accepted.
// - data byte done reports 0x28 on ack, 0x30 on not-ack.
// - flag cleared with start only sends a repeated start.
// - flag cleared with stop only sends stop, then stop bit self-clears.
// - start and stop both set: stop, clear stop bit, then start.
// - 0x38 with start clear releases bus, enters not-addressed slave.
// - 0x38 with start set waits for free bus, then sends start.
// - clock line held low after byte and ack while flag is set, except after arbitration loss without slave entry.
// - status code in upper five bits, latched at flag set, low bits zero.
// - set port ones set control bits, clear port ones clear them.
`timescale 1ns/10ps
`default_nettype none
module imts_ctrl
  import imts_pkg::*;
#(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // i2c pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // interrupt request
  output logic irq
);
  imts_state_t state_r, state_nxt;
  logic [7:0] con_r, con_nxt, adr_r, stat_r, shift_r, shift_nxt, code_set;
  logic [CW-1:0] scl_high_count_r, scl_low_count_r, tmr_r, tmr_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic lost_r, lost_nxt, first_r, first_nxt, rx_r, rx_nxt, rep_r, rep_nxt;
  logic ph_r, ph_nxt, scl_drv_nxt, sda_drv_nxt, si_set, sto_clr;
  logic scl_s, sda_s, sda_prev_r, busy_r, ack_now, lost_ack, lost_all;

  // pins pass the three-stage filter before any logic looks at them
  imts_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .clock(clock),
    .nrst(nrst),
    .din(scl_in),
    .dout(scl_s)
  );
  imts_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .clock(clock),
    .nrst(nrst),
    .din(sda_in),
    .dout(sda_s)
  );

  // apb decode; no wait state, read data comes from a flop loaded in the setup cycle
  wire setup_ph = psel && !penable;
  wire acc_done = psel && penable && pready;
  wire wr = acc_done && pwrite;
  wire hit_control_set_port = paddr == OFF_CONTROL_SET_PORT;
  wire hit_stat = paddr == OFF_STAT;
  wire hit_dat = paddr == OFF_DAT;
  wire hit_adr = paddr == OFF_ADR;
  wire hit_scl_high_count = paddr == OFF_SCL_HIGH_COUNT;
  wire hit_scl_low_count = paddr == OFF_SCL_LOW_COUNT;
  wire hit_control_clear_port = paddr == OFF_CONTROL_CLEAR_PORT;
  wire hit_any = hit_control_set_port | hit_stat | hit_dat | hit_adr | hit_scl_high_count | hit_scl_low_count | hit_control_clear_port;
  wire [31:0] rd_mux = hit_control_set_port ? {24'h0000_00, con_r} :
                       hit_stat ? {24'h0000_00, stat_r} :
                       hit_dat ? {24'h0000_00, shift_r} :
                       hit_adr ? {24'h0000_00, adr_r} :
                       hit_scl_high_count ? {{(32-CW){1'b0}}, scl_high_count_r} :
                       hit_scl_low_count ? {{(32-CW){1'b0}}, scl_low_count_r} : 32'h0000_0000;

  // control bit views
  wire en = con_r[CON_EN];
  wire start_request_bit = con_r[CON_STA];
  wire stop_request_bit = con_r[CON_STO];
  wire si = con_r[CON_SI];
  wire aa = con_r[CON_AA];
  // the shift register is only loaded while the engine is parked
  wire dat_wr = wr && hit_dat && (si || state_r == S_IDLE);
  wire tmr_done = tmr_r == '0;
  wire [CW-1:0] tmr_dec = tmr_r - 1'b1;
  wire tx_byte = first_r || !rx_r;
  wire ack_slot = bit_r == BITS_PER_BYTE;
  wire own_match = shift_r[7:1] == adr_r[7:1];
  wire gc_match = shift_r == 8'h00 && adr_r[0];
  // a slave ack is given only with ack enable set
  wire slave_ack = lost_r && first_r && aa && (own_match || gc_match);

  // control register: software set/clear, hardware set wins over any clear
  wire [7:0] sw_set = (wr && hit_control_set_port) ? pwdata[7:0] : 8'h00;
  wire [7:0] sw_clr = (wr && hit_control_clear_port) ? pwdata[7:0] : 8'h00;
  wire [7:0] hw_clr = sto_clr ? (8'h01 << CON_STO) : 8'h00;
  wire [7:0] hw_set = si_set ? (8'h01 << CON_SI) : 8'h00;
  assign con_nxt = (((con_r & ~sw_clr & ~hw_clr) | sw_set) | hw_set) & CON_VALID;

  // ack-slot sampling: low is ack, high is not-ack
  assign ack_now = !sda_s;
  // losing the not-ack of master receive counts as arbitration loss
  assign lost_ack = ack_slot && !first_r && rx_r && !aa && !sda_s;
  assign lost_all = lost_r || lost_ack;

  // status code chosen at the end of a start or of an acknowledge slot
  always_comb begin
    code_set = SC_ARB;
    if (state_r == S_START) begin
      code_set = rep_r ? SC_RSTART : SC_START;
    end else if (lost_all) begin
      if (slave_ack && own_match) begin
        code_set = shift_r[0] ? SC_SL_R : SC_SL_W;
      end else if (slave_ack) begin
        code_set = SC_SL_GC;
      end else begin
        code_set = SC_ARB;
      end
    end else if (first_r && shift_r[0]) begin
      code_set = ack_now ? SC_AR_ACK : SC_AR_NACK;
    end else if (first_r) begin
      code_set = ack_now ? SC_AW_ACK : SC_AW_NACK;
    end else if (rx_r) begin
      code_set = aa ? SC_RX_ACK : SC_RX_NACK;
    end else begin
      code_set = ack_now ? SC_D_ACK : SC_D_NACK;
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    bit_nxt = bit_r;
    shift_nxt = dat_wr ? pwdata[7:0] : shift_r;
    lost_nxt = lost_r;
    first_nxt = first_r;
    rx_nxt = rx_r;
    rep_nxt = rep_r;
    ph_nxt = ph_r;
    scl_drv_nxt = scl_oe;
    sda_drv_nxt = sda_oe;
    si_set = 1'b0;
    sto_clr = 1'b0;
    unique case (state_r)
      S_IDLE: begin
        scl_drv_nxt = 1'b0;
        sda_drv_nxt = 1'b0;
        lost_nxt = 1'b0;
        rep_nxt = 1'b0;
        // only a free bus lets a start out
        if (en && start_request_bit && !si && !busy_r) begin
          state_nxt = S_START;
          tmr_nxt = scl_high_count_r;
        end
      end
      S_START: begin
        // data falls while clock is high
        sda_drv_nxt = 1'b1;
        if (tmr_done) begin
          state_nxt = S_HOLD;
          scl_drv_nxt = 1'b1;
          si_set = 1'b1;
          rep_nxt = 1'b1;
          first_nxt = 1'b1;
          rx_nxt = 1'b0;
        end else begin
          tmr_nxt = tmr_dec;
        end
      end
      S_HOLD: begin
        // clock stays low until the flag is cleared, or stays free after a loss without slave entry
        if (!en) begin
          state_nxt = S_IDLE;
        end else if (!si) begin
          tmr_nxt = scl_low_count_r;
          ph_nxt = 1'b0;
          if (lost_r) begin
            // after loss or slave entry the bus is left to the other master
            state_nxt = S_IDLE;
            scl_drv_nxt = 1'b0;
            sda_drv_nxt = 1'b0;
          end else if (stop_request_bit) begin
            state_nxt = S_STOP;
            sda_drv_nxt = 1'b1;
          end else if (start_request_bit) begin
            state_nxt = S_RSTA;
            sda_drv_nxt = 1'b0;
          end else begin
            // next byte: address, data out or data in
            state_nxt = S_LOW;
            bit_nxt = 4'h0;
            sda_drv_nxt = tx_byte && !shift_r[7];
          end
        end
      end
      S_LOW: begin
        scl_drv_nxt = 1'b1;
        if (!ack_slot) begin
          sda_drv_nxt = tx_byte && !lost_r && !shift_r[7];
        end else begin
          // master receive acks by aa; a won-over slave acks its address
          sda_drv_nxt = (!first_r && rx_r && aa && !lost_r) || slave_ack;
        end
        if (tmr_done) begin
          state_nxt = S_HIGH;
          scl_drv_nxt = 1'b0;
          tmr_nxt = scl_high_count_r;
        end else begin
          tmr_nxt = tmr_dec;
        end
      end
      S_HIGH: begin
        // a slave stretching the clock freezes the high count
        if (scl_s && tmr_done) begin
          tmr_nxt = scl_low_count_r;
          if (!ack_slot) begin
            shift_nxt = {shift_r[6:0], sda_s};
            // a driven one read back low loses arbitration; clocking goes on
            if (tx_byte && !lost_r && shift_r[7] && !sda_s) begin
              lost_nxt = 1'b1;
            end
            bit_nxt = bit_r + 4'h1;
            state_nxt = S_LOW;
            scl_drv_nxt = 1'b1;
          end else begin
            state_nxt = S_HOLD;
            si_set = 1'b1;
            lost_nxt = lost_all;
            first_nxt = 1'b0;
            rx_nxt = first_r ? shift_r[0] : rx_r;
            // lost without slave entry releases both lines at once
            scl_drv_nxt = !(lost_all && !slave_ack);
            sda_drv_nxt = 1'b0;
            if (lost_all && slave_ack) begin
              rx_nxt = !shift_r[0];
            end
          end
        end else if (scl_s) begin
          tmr_nxt = tmr_dec;
        end
      end
      S_STOP: begin
        // data held low through a low then high clock, then released
        if (!ph_r && tmr_done) begin
          ph_nxt = 1'b1;
          scl_drv_nxt = 1'b0;
          tmr_nxt = scl_high_count_r;
        end else if (!ph_r) begin
          tmr_nxt = tmr_dec;
        end else if (scl_s && tmr_done) begin
          sda_drv_nxt = 1'b0;
          sto_clr = 1'b1;
          state_nxt = S_IDLE;
        end else if (scl_s) begin
          tmr_nxt = tmr_dec;
        end
      end
      S_RSTA: begin
        // data released in the low phase, clock released, then a start
        if (!ph_r && tmr_done) begin
          ph_nxt = 1'b1;
          scl_drv_nxt = 1'b0;
          tmr_nxt = scl_high_count_r;
        end else if (!ph_r) begin
          tmr_nxt = tmr_dec;
        end else if (scl_s && tmr_done) begin
          state_nxt = S_START;
          tmr_nxt = scl_high_count_r;
        end else if (scl_s) begin
          tmr_nxt = tmr_dec;
        end
      end
      default: begin
        state_nxt = S_IDLE;
        scl_drv_nxt = 1'b0;
        sda_drv_nxt = 1'b0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      tmr_r <= '0;
      bit_r <= 4'h0;
      shift_r <= DAT_RST;
      lost_r <= 1'b0;
      first_r <= 1'b0;
      rx_r <= 1'b0;
      rep_r <= 1'b0;
      ph_r <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      lost_r <= lost_nxt;
      first_r <= first_nxt;
      rx_r <= rx_nxt;
      rep_r <= rep_nxt;
      ph_r <= ph_nxt;
      scl_oe <= scl_drv_nxt;
      sda_oe <= sda_drv_nxt;
    end
  end

  // bus monitor: start marks busy, stop marks free
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sda_prev_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      sda_prev_r <= sda_s;
      if (scl_s && sda_prev_r && !sda_s) begin
        busy_r <= 1'b1;
      end else if (scl_s && !sda_prev_r && sda_s) begin
        busy_r <= 1'b0;
      end
    end
  end

  // register file and status latch
  always_ff @(posedge clock) begin
    if (!nrst) begin
      con_r <= CON_RST;
      adr_r <= ADR_RST;
      scl_high_count_r <= CW'(SCL_CNT_RST);
      scl_low_count_r <= CW'(SCL_CNT_RST);
      stat_r <= SC_NONE;
    end else begin
      con_r <= con_nxt;
      if (wr && hit_adr) begin
        adr_r <= pwdata[7:0];
      end
      if (wr && hit_scl_high_count) begin
        scl_high_count_r <= pwdata[CW-1:0];
      end
      if (wr && hit_scl_low_count) begin
        scl_low_count_r <= pwdata[CW-1:0];
      end
      // code is stable while the flag is set
      if (si_set) begin
        stat_r <= code_set;
      end else if (si && !con_nxt[CON_SI]) begin
        stat_r <= SC_NONE;
      end
    end
  end

  // apb answer and pin/irq outputs, all from flops
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      prdata <= setup_ph ? rd_mux : 32'h0000_0000;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      irq <= con_nxt[CON_SI] && con_nxt[CON_EN];
    end
  end
endmodule // imts_ctrl
`default_nettype wire

// ===== dv/imts_ctrl_assertions.sv
// concurrent checks on the controller's apb and open drain ports
`timescale 1ns/10ps
`default_nettype none
module imts_ctrl_assertions
  import imts_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // i2c pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // start: data pulled while the clock is free, clock pulled soon after
  sequence start_edge_s;
    !scl_oe && $rose(sda_oe);
  endsequence
  sequence stop_edge_s;
    !scl_oe && $fell(sda_oe);
  endsequence
  sequence clr_si_s;
    psel && penable && pready && pwrite && paddr == OFF_CONTROL_CLEAR_PORT && pwdata[CON_SI];
  endsequence
  // apb answers exactly one cycle after setup
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  stat_low_zero_a: assert property (pready && !pwrite && paddr == OFF_STAT |->
    prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("status low bits not zero");
  open_drain_zero_a: assert property (!scl_out && !sda_out)
    else $error("open drain value not zero");
  start_then_clock_a: assert property (start_edge_s |-> ##[1:40] scl_oe)
    else $error("no clock after start");
  // a stop leaves the clock free for a while
  stop_frees_bus_a: assert property (stop_edge_s |=> !scl_oe [*3])
    else $error("clock pulled right after stop");
  // scl_oe moves on the same edge that raises irq; three cycles of flag look past that edge
  scl_hold_a: assert property (irq [*3] |-> $stable(scl_oe))
    else $error("clock moved while flag set");
  irq_clear_a: assert property (clr_si_s |=> ##1 !irq)
    else $error("irq stays after flag clear");
endmodule // imts_ctrl_assertions
bind imts_ctrl imts_ctrl_assertions u_chk (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
);
`default_nettype wire

// ===== dv/imts_slave_model.sv
// behavioural i2c slave receiver for the far side of the bus
`timescale 1ns/10ps
`default_nettype none
module imts_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // bench control: refuse every byte
  input wire logic nack_all,
  // data pull and last byte seen
  output logic sda_oe,
  output logic [7:0] last_byte
);
  logic [7:0] shift_r = 8'h00;
  logic [3:0] cnt_r = 4'hA;
  logic first_r = 1'b0;
  initial sda_oe = 1'b0;
  initial last_byte = 8'h00;
  // start and stop are data edges while the clock is high
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      cnt_r = 4'h0;
      first_r = 1'b1;
      sda_oe = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) cnt_r = 4'hA;
  end
  // bits taken while the clock is high, msb first
  always @(posedge scl) begin
    if (cnt_r < 4'h8) begin
      shift_r = {shift_r[6:0], sda};
      cnt_r = cnt_r + 4'h1;
    end
  end
  // ack pulled after the eighth bit, released after the ninth
  always @(negedge scl) begin
    if (cnt_r == 4'h8) begin
      last_byte = shift_r;
      sda_oe = !nack_all && (!first_r || shift_r == {ADDR, 1'b0});
      cnt_r = 4'h9;
    end else if (cnt_r == 4'h9) begin
      sda_oe = 1'b0;
      cnt_r = 4'h0;
      first_r = 1'b0;
    end
  end
endmodule // imts_slave_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench: apb register sequences against the slave model
`timescale 1ns/10ps
`default_nettype none
module tb;
  import imts_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, slv_oe, scl_w, sda_w, err;
  logic nack_all = 1'b0;
  logic arb_pull = 1'b0;
  logic [7:0] slv_byte;
  int fail_count = 0;
  int checks = 0;
  // open drain wires with pull-ups; bit time near 80 ns with counts of 5
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe | slv_oe | arb_pull);
  always #2.5 clock = !clock;
  imts_ctrl #(.CW(16)) dut (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
  );
  imts_slave_model #(.ADDR(7'h2A)) u_slave (
    .scl(scl_w), .sda(sda_w), .nack_all(nack_all), .sda_oe(slv_oe), .last_byte(slv_byte)
  );
  task automatic summarize();
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timed_out();
    fail_count++;
    $display("Error at %0t: wait ran out", $time);
    summarize();
  endtask
  // one transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timed_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // irq is registered: let a cleared flag reach it before polling
  task automatic wait_irq();
    int n;
    n = 0;
    repeat (2) @(posedge clock);
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (irq !== 1'b1) timed_out();
  endtask
  task automatic go(input logic [7:0] set, input logic [7:0] clr, input logic [7:0] exp);
    if (set != 8'h00) apb(1'b1, OFF_CONTROL_SET_PORT, {24'h0, set});
    if (clr != 8'h00) apb(1'b1, OFF_CONTROL_CLEAR_PORT, {24'h0, clr});
    wait_irq();
    apb(1'b0, OFF_STAT, 32'h0);
    check(rd, {24'h0, exp});
  endtask
  initial begin
    int n;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    apb(1'b0, OFF_CONTROL_SET_PORT, 32'h0);
    check(rd, {24'h0, CON_RST});
    apb(1'b0, OFF_STAT, 32'h0);
    check(rd, {24'h0, SC_NONE});
    apb(1'b0, OFF_SCL_HIGH_COUNT, 32'h0);
    check(rd, {16'h0, SCL_CNT_RST});
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, err}, 32'h1);
    // bit rate first, then enable with every request bit clear
    apb(1'b1, OFF_SCL_HIGH_COUNT, 32'h0000_0005);
    apb(1'b1, OFF_SCL_LOW_COUNT, 32'h0000_0005);
    apb(1'b1, OFF_CONTROL_SET_PORT, 32'h0000_0040);
    apb(1'b0, OFF_CONTROL_SET_PORT, 32'h0);
    check(rd, 32'h0000_0040);
    go(8'h20, 8'h00, SC_START);
    check({31'h0, irq}, 32'h1);
    repeat (50) @(posedge clock);
    check({31'h0, scl_w}, 32'h0);
    apb(1'b0, OFF_STAT, 32'h0);
    check(rd, {24'h0, SC_START});
    apb(1'b1, OFF_DAT, 32'h0000_0054);
    go(8'h00, 8'h28, SC_AW_ACK);
    check({24'h0, slv_byte}, 32'h0000_0054);
    apb(1'b1, OFF_DAT, 32'h0000_00A5);
    go(8'h00, 8'h08, SC_D_ACK);
    check({24'h0, slv_byte}, 32'h0000_00A5);
    nack_all <= 1'b1;
    apb(1'b1, OFF_DAT, 32'h0000_003C);
    go(8'h00, 8'h08, SC_D_NACK);
    nack_all <= 1'b0;
    go(8'h20, 8'h08, SC_RSTART);
    apb(1'b1, OFF_DAT, 32'h0000_0056);
    go(8'h00, 8'h28, SC_AW_NACK);
    go(8'h30, 8'h08, SC_START);
    apb(1'b0, OFF_CONTROL_SET_PORT, 32'h0);
    check(rd, 32'h0000_0068);
    apb(1'b1, OFF_DAT, 32'h0000_0054);
    go(8'h00, 8'h28, SC_AW_ACK);
    // a rival pulls the data line under our first one bit
    nack_all <= 1'b1;
    apb(1'b1, OFF_DAT, 32'h0000_00FF);
    arb_pull <= 1'b1;
    go(8'h00, 8'h08, SC_ARB);
    check({31'h0, scl_w}, 32'h1);
    apb(1'b1, OFF_CONTROL_SET_PORT, 32'h0000_0020);
    apb(1'b1, OFF_CONTROL_CLEAR_PORT, 32'h0000_0008);
    repeat (100) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    arb_pull <= 1'b0;
    go(8'h00, 8'h00, SC_START);
    nack_all <= 1'b0;
    apb(1'b1, OFF_DAT, 32'h0000_0054);
    go(8'h00, 8'h28, SC_AW_ACK);
    // repeated start, then the read bit: the model refuses reads, so 0x48
    go(8'h20, 8'h08, SC_RSTART);
    apb(1'b1, OFF_DAT, 32'h0000_0055);
    go(8'h00, 8'h28, SC_AR_NACK);
    check({24'h0, slv_byte}, 32'h0000_0055);
    apb(1'b1, OFF_CONTROL_SET_PORT, 32'h0000_0010);
    apb(1'b1, OFF_CONTROL_CLEAR_PORT, 32'h0000_0008);
    n = 0;
    do begin
      apb(1'b0, OFF_CONTROL_SET_PORT, 32'h0);
      n++;
    end while (rd[CON_STO] && n < 50);
    check(rd, 32'h0000_0040);
    repeat (20) @(posedge clock);
    check({30'h0, scl_w, sda_w}, 32'h3);
    check({31'h0, irq}, 32'h0);
    summarize();
  end
endmodule // tb
`default_nettype wire
